// file: bench/port_one_policy_properties.sv
// Checker for port one per-packet decisions and port controls.
// Assumes binding to port_one_policy, one clock, async active-low reset.
`timescale 1ns/1ps
`default_nettype none
module port_one_policy_props (
  input wire logic hclk,
  input wire logic hresetn,
  input wire port_one_pkg::pkt_info_s pkt_info,
  input wire logic pkt_is_egress,
  input wire port_one_pkg::pkt_decision_s pkt_decision,
  input wire port_one_pkg::port_ctrl_s port_ctrl
);
  import port_one_pkg::*;
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  insert_untagged_a: assert property (pkt_decision.add_tag |->
    $past(pkt_is_egress) && !$past(pkt_info.rx_tagged)) else $error("bad add");
  insert_vid_a: assert property (pkt_decision.add_tag |->
    pkt_decision.add_tag_vid == $past(pkt_info.ingress_pvid))
    else $error("bad tag vid");
  strip_tagged_a: assert property (pkt_decision.strip_tag |->
    $past(pkt_is_egress) && $past(pkt_info.rx_tagged)) else $error("bad strip");
  queue_class_a: assert property (pkt_decision.out_queue != 2'h0 |->
    pkt_decision.out_queue == $past(pkt_info.class_queue))
    else $error("bad queue");
  prio_clamp_a: assert property (pkt_decision.out_prio <=
    $past(pkt_info.pkt_prio)) else $error("priority raised");
  tx_gate_a: assert property ($past(hresetn)
    && $past(pkt_is_egress) |-> pkt_decision.drop == !port_ctrl.tx_allowed)
    else $error("bad tx drop");
  rx_gate_a: assert property ($past(hresetn)
    && !$past(pkt_is_egress) && !port_ctrl.rx_allowed |-> pkt_decision.drop)
    else $error("rx not gated");
  monitor_dir_a: assert property (pkt_decision.mark_monitor |->
    ($past(pkt_is_egress) ? port_ctrl.tx_sniff : port_ctrl.rx_sniff))
    else $error("bad monitor mark");
  reset_ctrl_a: assert property ($rose(hresetn) |=>
    port_ctrl.members == 3'h7 && port_ctrl.tx_allowed && port_ctrl.rx_allowed
    && port_ctrl.learn_allowed) else $error("bad reset controls");
  cover property (pkt_decision.add_tag);
  cover property (pkt_decision.strip_tag);
  cover property (pkt_decision.drop);
endmodule // port_one_policy_props
bind port_one_policy port_one_policy_props u_props (.hclk, .hresetn,
  .pkt_info, .pkt_is_egress, .pkt_decision, .port_ctrl);
`default_nettype wire

// file: bench/port_one_policy_tb_top.sv
// Self-checking bench for port one policy control.
// Assumes the bench is the only AHB-Lite master; hready follows hreadyout.
`timescale 1ns/1ps
`default_nettype none
`include "port_one_regs.svh"
module port_one_policy_tb_top;
  import port_one_pkg::*;
  typedef struct {
    logic [15:0] c1;
    logic [15:0] c2;
    logic eg;
    pkt_info_s pi;
    pkt_decision_s ex;
  } row_s;
  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic hsel = 1'b0;
  logic [11:0] haddr = 12'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [2:0] hsize = 3'h2;
  logic [31:0] hwdata = 32'h0;
  logic [31:0] hrdata;
  logic hreadyout;
  logic hresp;
  pkt_info_s pi = '0;
  logic eg = 1'b0;
  pkt_decision_s pkt_decision;
  port_ctrl_s port_ctrl;
  int n_fail = 0;
  int checks_done = 0;
  int cyc = 0;
  logic [31:0] rd;
  row_s rows [9] = '{
    '{16'h0000, 16'h4607, 1'b0, '{1'b0, 12'h001, 3'h1, 3'h3, 2'h2, 12'h001,
      2'h0, 1'b0}, '{1'b0, 12'h0, 1'b0, 2'h0, 1'b1, 3'h1, 1'b0}},
    '{16'h0000, 16'h4607, 1'b0, '{1'b0, 12'h001, 3'h1, 3'h4, 2'h2, 12'h001,
      2'h0, 1'b0}, '{1'b0, 12'h0, 1'b0, 2'h0, 1'b0, 3'h1, 1'b0}},
    '{16'h0004, 16'h0607, 1'b1, '{1'b0, 12'h005, 3'h3, 3'h7, 2'h1, 12'h123,
      2'h2, 1'b0}, '{1'b1, 12'h123, 1'b0, 2'h0, 1'b0, 3'h3, 1'b0}},
    '{16'h0007, 16'h0627, 1'b1, '{1'b1, 12'h005, 3'h3, 3'h7, 2'h1, 12'h123,
      2'h2, 1'b0}, '{1'b0, 12'h0, 1'b1, 2'h2, 1'b0, 3'h3, 1'b1}},
    '{16'h0000, 16'h020F, 1'b1, '{1'b0, 12'h005, 3'h5, 3'h7, 2'h1, 12'h123,
      2'h0, 1'b0}, '{1'b0, 12'h0, 1'b0, 2'h0, 1'b1, 3'h0, 1'b0}},
    '{16'h0000, 16'h4646, 1'b0, '{1'b1, 12'h001, 3'h2, 3'h6, 2'h0, 12'h001,
      2'h0, 1'b0}, '{1'b0, 12'h0, 1'b0, 2'h0, 1'b1, 3'h2, 1'b1}},
    '{16'h0000, 16'h2607, 1'b0, '{1'b1, 12'h005, 3'h2, 3'h7, 2'h0, 12'h001,
      2'h0, 1'b0}, '{1'b0, 12'h0, 1'b0, 2'h0, 1'b1, 3'h2, 1'b0}},
    '{16'h0000, 16'h0407, 1'b0, '{1'b1, 12'h001, 3'h2, 3'h7, 2'h0, 12'h001,
      2'h0, 1'b0}, '{1'b0, 12'h0, 1'b0, 2'h0, 1'b1, 3'h2, 1'b0}},
    '{16'h0000, 16'h6607, 1'b0, '{1'b1, 12'h001, 3'h2, 3'h7, 2'h0, 12'h001,
      2'h0, 1'b0}, '{1'b0, 12'h0, 1'b0, 2'h0, 1'b0, 3'h2, 1'b0}}};

  port_one_policy u_dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
    .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .pkt_info(pi), .pkt_is_egress(eg),
    .pkt_decision(pkt_decision), .port_ctrl(port_ctrl));

  always #50 hclk = ~hclk;

  task automatic complete_run;
    $display("checks %0d mismatches %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask

  always @(posedge hclk) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      n_fail++;
      complete_run();
    end
  end

  task automatic bus(input logic w, input logic [11:0] a,
      input logic [31:0] wd);
    @(posedge hclk);
    hsel <= 1'b1;
    haddr <= a;
    hwrite <= w;
    htrans <= 2'h2;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask

  task automatic wr_rd(input logic [11:0] a, input logic [31:0] wd);
    @(posedge hclk);
    hsel <= 1'b1;
    haddr <= a;
    hwrite <= 1'b1;
    htrans <= 2'h2;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    hwrite <= 1'b0;
    hwdata <= wd;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask

  task automatic chk_v(input string n, input logic [31:0] e,
      input logic [31:0] s);
    checks_done++;
    if (s !== e) begin
      n_fail++;
      $display("[ERR] %s expected %h seen %h", n, e, s);
    end
  endtask

  task automatic rd_chk(input logic [11:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0);
    chk_v("register", e, rd);
    chk_v("hresp", 32'h0, {31'h0, hresp});
  endtask

  task automatic chk_d(input pkt_decision_s e);
    pkt_decision_s s;
    s = pkt_decision;
    if (e.add_tag === 1'b0) s.add_tag_vid = e.add_tag_vid;
    chk_v("decision", 32'(e), 32'(s));
  endtask

  task automatic ctrl_chk(input port_ctrl_s e);
    repeat (2) @(posedge hclk);
    @(negedge hclk);
    chk_v("port_ctrl", 32'(e), 32'(port_ctrl));
  endtask

  task automatic do_reset;
    hresetn <= 1'b0;
    repeat (10) @(posedge hclk);
    hresetn <= 1'b1;
  endtask

  initial begin
    do_reset();
    foreach (rows[i]) begin
      bus(1'b1, `CTRL_FIRST_WORD, {16'h0, rows[i].c1});
      bus(1'b1, `CTRL_SECOND_WORD, {16'h0, rows[i].c2});
      @(posedge hclk);
      pi <= rows[i].pi;
      eg <= rows[i].eg;
      @(posedge hclk);
      @(negedge hclk);
      chk_d(rows[i].ex);
    end
    $display("decision rows done");
    @(posedge hclk);
    pi <= '0;
    do_reset();
    ctrl_chk(11'h1C7);
    rd_chk(`CTRL_FIRST_WORD, 32'h0);
    rd_chk(`CTRL_SECOND_WORD, 32'h607);
    rd_chk(`DEFAULT_TAG_WORD, 32'h1);
    $display("reset test done");
    bus(1'b1, `CTRL_FIRST_WORD, 32'hFFFF);
    rd_chk(`CTRL_FIRST_WORD, 32'h7FFF);
    bus(1'b1, `CTRL_SECOND_WORD, 32'hFFFF);
    rd_chk(`CTRL_SECOND_WORD, 32'hFFFF);
    bus(1'b1, `DEFAULT_TAG_WORD, 32'hABCD);
    rd_chk(`DEFAULT_TAG_WORD, 32'hABCD);
    bus(1'b1, 12'h0F0, 32'h1234);
    rd_chk(12'h0F0, 32'h0);
    wr_rd(`CTRL_SECOND_WORD, 32'h0A5A);
    chk_v("forward second", 32'h0A5A, rd);
    wr_rd(`CTRL_FIRST_WORD, 32'h8003);
    chk_v("forward first", 32'h0003, rd);
    $display("register access test done");
    bus(1'b1, `CTRL_SECOND_WORD, 32'h1980);
    ctrl_chk(11'h620);
    @(posedge hclk);
    pi <= '{1'b0, 12'h0, 3'h0, 3'h0, 2'h0, 12'h0, 2'h0, 1'b1};
    bus(1'b1, `CTRL_SECOND_WORD, 32'h0062);
    ctrl_chk(11'h45A);
    $display("port control test done");
    complete_run();
  end
endmodule // port_one_policy_tb_top
`default_nettype wire

// file: logic/port_one_policy.sv
// Port one policy control: registers over AHB-Lite, per-packet decisions.
// Assumes one AHB-Lite master, word transfers, core facts from same clock.
//
// Operation
// R1 - Tag insert: untagged arrivals gain a tag on egress; tagged untouched.
// R2 - Inserted tag carries the ingress port's default VID.
// R3 - Tag strip: tagged arrivals lose their tag; untagged pass unmodified.
// R4 - Multi-queue splits output into queues 0-3; else single queue 0.
// R5 - Ingress filter drops packets whose VLAN members exclude ingress port.
// R6 - Non-default VID discard drops packets whose VID differs from default.
// R7 - Force flow control overrides auto-negotiation; else negotiated result.
// R8 - Back-pressure bit enables half-duplex back pressure.
// R9 - Transmit enable, reset one, gates all transmission.
// R10 - Receive enable, reset one, gates all reception.
// R11 - Learning disable stops address learning; reset allows it.
// R12 - Sniffer bit makes port the mirror destination.
// R13 - Receive mirror marks received packets monitored.
// R14 - Transmit mirror marks transmitted packets monitored.
// R15 - Priority ceiling clamps priority to default user priority.
// R16 - Membership field, reset all ones, limits forwarding to members.
// R17 - Membership bit two host, bit one port two, bit zero port one.
// R18 - Default tag VID is twelve bits, resets to one.
// R19 - Reserved read-write bits store and return written values.
`timescale 1ns/1ps
`default_nettype none
`include "port_one_regs.svh"

module port_one_policy (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [11:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire port_one_pkg::pkt_info_s pkt_info,
  input wire logic pkt_is_egress,
  output port_one_pkg::pkt_decision_s pkt_decision,
  output port_one_pkg::port_ctrl_s port_ctrl
);
  import port_one_pkg::*;

  logic [15:0] ctrl_first_reg;
  logic [15:0] ctrl_second_reg;
  logic [15:0] default_tag_reg;
  bus_state_e bus_state_reg;
  logic [11:0] wr_addr_reg;
  logic [31:0] hrdata_next;
  logic [31:0] hrdata_reg;
  logic addr_phase;
  pkt_decision_s decision_next;
  pkt_decision_s decision_reg;
  port_ctrl_s ctrl_next;
  port_ctrl_s ctrl_reg;
  logic [2:0] ingress_onehot;
  logic wr_pending;
  logic [15:0] fwd_word;
  logic [2:0] member_hit;
  vid_t default_vid;
  prio_t default_prio;
  logic tag_add;
  logic tag_strip;
  logic [1:0] queue_sel;
  logic drop_filter;
  logic drop_vid;
  logic drop_rx;
  logic drop_tx;
  logic drop_any;
  prio_t prio_sel;
  logic monitor_sel;
  logic flow_on;

  assign addr_phase = hsel && hready && htrans[1];
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign hrdata = hrdata_reg;
  assign pkt_decision = decision_reg;
  assign port_ctrl = ctrl_reg;

  // Write address captured for the following data phase
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      bus_state_reg <= BUS_IDLE;
      wr_addr_reg <= 12'h000;
    end else begin
      case (bus_state_reg)
        BUS_IDLE: begin
          if (addr_phase && hwrite) begin
            bus_state_reg <= BUS_WRITE;
            wr_addr_reg <= haddr;
          end
        end
        BUS_WRITE: begin
          if (addr_phase && hwrite) begin
            wr_addr_reg <= haddr;
          end else begin
            bus_state_reg <= BUS_IDLE;
          end
        end
        default: begin
          bus_state_reg <= BUS_IDLE;
        end
      endcase
    end
  end

  // Data phase of a write, one process per register
  assign wr_pending = (bus_state_reg == BUS_WRITE);

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ctrl_first_reg <= `CTRL_FIRST_RESET;
    end else if (wr_pending && (wr_addr_reg == `CTRL_FIRST_WORD)) begin
      ctrl_first_reg <= hwdata[15:0] & `CTRL_FIRST_MASK;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ctrl_second_reg <= `CTRL_SECOND_RESET; // see R9 see R10 see R16
    end else if (wr_pending && (wr_addr_reg == `CTRL_SECOND_WORD)) begin
      ctrl_second_reg <= hwdata[15:0]; // see R19
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      default_tag_reg <= `DEFAULT_TAG_RESET; // see R18
    end else if (wr_pending && (wr_addr_reg == `DEFAULT_TAG_WORD)) begin
      default_tag_reg <= hwdata[15:0];
    end
  end

  // Word a pending write leaves in its register
  always_comb begin
    fwd_word = hwdata[15:0];
    if (wr_addr_reg == `CTRL_FIRST_WORD) begin
      fwd_word = hwdata[15:0] & `CTRL_FIRST_MASK;
    end
  end

  // Read data prepared in address phase, shown in data phase
  // Read right behind a write sees the written word, not the stale one
  always_comb begin
    hrdata_next = 32'h0000_0000;
    case (haddr)
      `CTRL_FIRST_WORD: begin
        hrdata_next = {16'h0000, ctrl_first_reg};
      end
      `CTRL_SECOND_WORD: begin
        hrdata_next = {16'h0000, ctrl_second_reg};
      end
      `DEFAULT_TAG_WORD: begin
        hrdata_next = {16'h0000, default_tag_reg};
      end
      default: begin
        hrdata_next = 32'h0000_0000;
      end
    endcase
    if (wr_pending && (wr_addr_reg == haddr)) begin
      case (haddr)
        `CTRL_FIRST_WORD, `CTRL_SECOND_WORD, `DEFAULT_TAG_WORD: begin
          hrdata_next = {16'h0000, fwd_word};
        end
        default: begin
          hrdata_next = 32'h0000_0000;
        end
      endcase
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata_reg <= 32'h0000_0000;
    end else if (addr_phase && !hwrite) begin
      hrdata_reg <= hrdata_next;
    end
  end

  // Ingress port number to membership position
  always_comb begin
    ingress_onehot = 3'h0;
    case (pkt_info.ingress_port)
      2'h0: ingress_onehot = 3'h1 << `PORT_ONE_MEMBER_BIT; // see R17
      2'h1: ingress_onehot = 3'h1 << `PORT_TWO_MEMBER_BIT; // see R17
      2'h2: ingress_onehot = 3'h1 << `HOST_MEMBER_BIT; // see R17
      default: ingress_onehot = 3'h0;
    endcase
  end

  // Ingress port found in the VLAN membership, bit by bit
  for (genvar i = 0; i < 3; i++) begin : g_member
    assign member_hit[i] = pkt_info.vlan_members[i] & ingress_onehot[i];
  end

  assign default_vid = default_tag_reg[`VID_MSB:0]; // see R18
  assign default_prio = default_tag_reg[`PRIO_MSB:`PRIO_LSB];

  // Egress tag edits
  always_comb begin
    tag_add = 1'b0;
    tag_strip = 1'b0;
    if (pkt_is_egress) begin
      if (!pkt_info.rx_tagged && ctrl_first_reg[`BIT_TAG_INSERT]) begin
        tag_add = 1'b1; // see R1
      end
      if (pkt_info.rx_tagged && ctrl_first_reg[`BIT_TAG_STRIP]) begin
        tag_strip = 1'b1; // see R3
      end
    end
  end

  // Output queue choice
  always_comb begin
    queue_sel = 2'h0;
    if (ctrl_first_reg[`BIT_MULTI_QUEUE]) begin
      queue_sel = pkt_info.class_queue; // see R4
    end
  end

  // Drop reasons; ingress ones apply only to ingress decisions
  always_comb begin
    drop_filter = 1'b0;
    drop_vid = 1'b0;
    drop_rx = 1'b0;
    drop_tx = 1'b0;
    if (!pkt_is_egress) begin
      if (ctrl_second_reg[`BIT_VLAN_FILTER] && (member_hit == 3'h0)) begin
        drop_filter = 1'b1; // see R5
      end
      if (ctrl_second_reg[`BIT_NON_PVID_DROP]
          && (pkt_info.pkt_vid != default_vid)) begin
        drop_vid = 1'b1; // see R6
      end
      if (!ctrl_second_reg[`BIT_RX_ENABLE]) begin
        drop_rx = 1'b1; // see R10
      end
    end else begin
      if (!ctrl_second_reg[`BIT_TX_ENABLE]) begin
        drop_tx = 1'b1; // see R9
      end
    end
  end

  assign drop_any = drop_filter || drop_vid || drop_rx || drop_tx;

  // Priority ceiling
  always_comb begin
    prio_sel = pkt_info.pkt_prio;
    if (ctrl_second_reg[`BIT_PRIO_CEILING]
        && (pkt_info.pkt_prio > default_prio)) begin
      prio_sel = default_prio; // see R15
    end
  end

  // Monitor mark by direction
  always_comb begin
    monitor_sel = ctrl_second_reg[`BIT_RX_SNIFF]; // see R13
    if (pkt_is_egress) begin
      monitor_sel = ctrl_second_reg[`BIT_TX_SNIFF]; // see R14
    end
  end

  // Per-packet decisions gathered for the register stage
  always_comb begin
    decision_next = '0;
    decision_next.add_tag = tag_add;
    decision_next.add_tag_vid = pkt_info.ingress_pvid; // see R2
    decision_next.strip_tag = tag_strip;
    decision_next.out_queue = queue_sel;
    decision_next.drop = drop_any;
    decision_next.out_prio = prio_sel;
    decision_next.mark_monitor = monitor_sel;
  end

  // Flow control forced on, else the negotiated result
  always_comb begin
    flow_on = pkt_info.aneg_flow_ctrl;
    if (ctrl_second_reg[`BIT_FORCE_FC]) begin
      flow_on = 1'b1; // see R7
    end
  end

  // Static port controls
  always_comb begin
    ctrl_next = '0;
    ctrl_next.flow_ctrl_on = flow_on; // see R7
    ctrl_next.back_pressure_on = ctrl_second_reg[`BIT_BACK_PRESSURE]; // see R8
    ctrl_next.tx_allowed = ctrl_second_reg[`BIT_TX_ENABLE]; // see R9
    ctrl_next.rx_allowed = ctrl_second_reg[`BIT_RX_ENABLE]; // see R10
    ctrl_next.learn_allowed = !ctrl_second_reg[`BIT_LEARN_DISABLE]; // see R11
    ctrl_next.is_sniffer = ctrl_second_reg[`BIT_SNIFFER]; // see R12
    ctrl_next.rx_sniff = ctrl_second_reg[`BIT_RX_SNIFF]; // see R13
    ctrl_next.tx_sniff = ctrl_second_reg[`BIT_TX_SNIFF]; // see R14
    ctrl_next.members = ctrl_second_reg[`MEMBER_MSB:0]; // see R16
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      decision_reg <= '0;
    end else begin
      decision_reg <= decision_next;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ctrl_reg <= '0;
    end else begin
      ctrl_reg <= ctrl_next;
    end
  end
endmodule // port_one_policy

`default_nettype wire

// file: shared/port_one_pkg.sv
// Types shared by the port one policy control block.
// Assumes the register header supplies all numeric constants.
package port_one_pkg;
  typedef logic [11:0] vid_t;
  typedef logic [2:0] prio_t;
  typedef logic [2:0] member_t;

  // Per-packet facts offered by the switch core for the packet in hand
  typedef struct packed {
    logic rx_tagged;
    vid_t pkt_vid;
    prio_t pkt_prio;
    member_t vlan_members;
    logic [1:0] ingress_port;
    vid_t ingress_pvid;
    logic [1:0] class_queue;
    logic aneg_flow_ctrl;
  } pkt_info_s;

  // Per-packet decisions returned to the switch core
  typedef struct packed {
    logic add_tag;
    vid_t add_tag_vid;
    logic strip_tag;
    logic [1:0] out_queue;
    logic drop;
    prio_t out_prio;
    logic mark_monitor;
  } pkt_decision_s;

  // Static port controls
  typedef struct packed {
    logic flow_ctrl_on;
    logic back_pressure_on;
    logic tx_allowed;
    logic rx_allowed;
    logic learn_allowed;
    logic is_sniffer;
    logic rx_sniff;
    logic tx_sniff;
    member_t members;
  } port_ctrl_s;

  typedef enum logic [1:0] {
    BUS_IDLE = 2'b00,
    BUS_WRITE = 2'b01
  } bus_state_e;
endpackage

// file: shared/port_one_regs.svh
// Register offsets, field positions and reset values for port one control.
// Assumes AHB-Lite byte addressing: each register index times four.
`ifndef PORT_ONE_REGS_SVH
`define PORT_ONE_REGS_SVH

`define CTRL_FIRST_OFFSET 12'h06C
`define CTRL_SECOND_OFFSET 12'h06E
`define DEFAULT_TAG_OFFSET 12'h070
`define CTRL_FIRST_WORD 12'h1B0
`define CTRL_SECOND_WORD 12'h1B8
`define DEFAULT_TAG_WORD 12'h1C0
`define CTRL_FIRST_RESET 16'h0000
`define CTRL_SECOND_RESET 16'h0607
`define DEFAULT_TAG_RESET 16'h0001
`define CTRL_FIRST_MASK 16'h7FFF
`define BIT_TAG_INSERT 2
`define BIT_TAG_STRIP 1
`define BIT_MULTI_QUEUE 0
`define BIT_VLAN_FILTER 14
`define BIT_NON_PVID_DROP 13
`define BIT_FORCE_FC 12
`define BIT_BACK_PRESSURE 11
`define BIT_TX_ENABLE 10
`define BIT_RX_ENABLE 9
`define BIT_LEARN_DISABLE 8
`define BIT_SNIFFER 7
`define BIT_RX_SNIFF 6
`define BIT_TX_SNIFF 5
`define BIT_PRIO_CEILING 3
`define MEMBER_MSB 2
`define PRIO_MSB 15
`define PRIO_LSB 13
`define VID_MSB 11
`define HOST_MEMBER_BIT 2
`define PORT_TWO_MEMBER_BIT 1
`define PORT_ONE_MEMBER_BIT 0

`endif
